// File: rtl/scep_if.sv
// carrier between the register bank and the probe mux
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface scep_if;
  logic [2:0] sel;
  logic [7:0] flags;
  logic       probe;
  modport bank (output sel, output flags, input probe);
  modport mux  (input sel, input flags, output probe);
endinterface : scep_if

// File: rtl/scep_pkg.sv
// constants for the secure clock and error probe register bank
// assumes an 8-bit internal register bus with 16-bit byte addresses
package scep_pkg;
  localparam logic [15:0] SCEP_CTRL_ADDR    = 16'h6330;
  localparam logic [7:0]  SCEP_CTRL_RESET   = 8'h00;
  localparam int          SCEP_CLK_SEL_BIT  = 7;
  localparam int          SCEP_PROBE_EN_BIT = 3;
  localparam int          SCEP_SEL_MSB      = 2;
  localparam logic [7:0]  SCEP_CTRL_WMASK   = 8'h8f;
  localparam logic [3:0]  SCEP_AUX_ERR_CODE = 4'ha;
  localparam int          SCEP_NUM_ERR      = 8;

  typedef enum logic [2:0]
  {
    SCEP_SRC_PROTOCOL = 3'h0,
    SCEP_SRC_PARITY   = 3'h1,
    SCEP_SRC_CHECKSUM = 3'h2,
    SCEP_SRC_COLL     = 3'h3,
    SCEP_SRC_FIFO     = 3'h4,
    SCEP_SRC_FIELD    = 3'h5,
    SCEP_SRC_HEAT     = 3'h6,
    SCEP_SRC_WRITE    = 3'h7
  } scep_src_t;
endpackage : scep_pkg

// File: rtl/scep_probe_mux.sv
// error flag selector for the probe output
// assumes flags are already synchronous to i_clk_sys
`timescale 1ns/10ps
module scep_probe_mux
(
  scep_if.mux bus
);
  always_comb
  begin
    bus.probe = bus.flags[bus.sel];
  end
endmodule : scep_probe_mux

// File: rtl/scep_regs.sv
// secure clock pin select and error probe control register
// assumes a single-cycle 8-bit register bus from the core on i_clk_sys
`timescale 1ns/10ps
module scep_regs
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  output logic             o_hit,
  input  wire logic        i_secure_clk,
  input  wire logic        i_port_three_bit_four,
  output logic             o_pin_out,
  input  wire logic [3:0]  i_aux_output_select_one,
  input  wire logic [3:0]  i_aux_output_select_two,
  input  wire logic        i_protocol_violation_flag,
  input  wire logic        i_parity_fault_flag,
  input  wire logic        i_checksum_fault_flag,
  input  wire logic        i_collision_fault_flag,
  input  wire logic        i_fifo_overflow_flag,
  input  wire logic        i_field_fault_flag,
  input  wire logic        i_overheat_fault_flag,
  input  wire logic        i_write_fault_flag,
  output logic             o_aux_one,
  output logic             o_aux_two,
  output logic             o_error_probe_signal
);
  typedef struct packed
  {
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic       hit;
  } scep_state_t;

  scep_state_t state_reg;
  scep_state_t state_next;
  scep_if      pbus ();
  logic        sel_hit;
  logic        aux_on;

  scep_probe_mux u_mux
  (
    .bus (pbus.mux)
  );

  assign sel_hit = (i_addr == scep_pkg::SCEP_CTRL_ADDR);
  assign pbus.sel = state_reg.ctrl[scep_pkg::SCEP_SEL_MSB:0];
  assign pbus.flags = {i_write_fault_flag, i_overheat_fault_flag,
                       i_field_fault_flag, i_fifo_overflow_flag,
                       i_collision_fault_flag, i_checksum_fault_flag,
                       i_parity_fault_flag, i_protocol_violation_flag};

  always_comb
  begin
    state_next = state_reg;
    state_next.hit = 1'b0;
    // only the core writes; no bit here is dynamic, so no internal write port
    if (i_wr && sel_hit)
    begin
      // reserved bits are masked off at the write, so they always read zero
      state_next.ctrl = i_wdata & scep_pkg::SCEP_CTRL_WMASK;
    end
    if (i_rd)
    begin
      state_next.hit = sel_hit;
      // unmapped, reserved or write-only bytes read zero
      state_next.rdata = sel_hit ? state_reg.ctrl : 8'h00;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_reg.ctrl  <= scep_pkg::SCEP_CTRL_RESET;
      state_reg.rdata <= 8'h00;
      state_reg.hit   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign aux_on = state_reg.ctrl[scep_pkg::SCEP_PROBE_EN_BIT]
    && (i_aux_output_select_one == scep_pkg::SCEP_AUX_ERR_CODE)
    && (i_aux_output_select_two == scep_pkg::SCEP_AUX_ERR_CODE);

  // pin mux is combinational: the secure clock must not be resampled
  always_comb
  begin
    o_pin_out = state_reg.ctrl[scep_pkg::SCEP_CLK_SEL_BIT] ? i_secure_clk
                : i_port_three_bit_four;
    o_error_probe_signal = pbus.probe;
    o_aux_one = aux_on ? pbus.probe : 1'b0;
    o_aux_two = aux_on ? pbus.probe : 1'b0;
  end

  assign o_rdata = state_reg.rdata;
  assign o_hit = state_reg.hit;

  property p_write_takes;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_wr && sel_hit) |=> (state_reg.ctrl == ($past(i_wdata) & 8'h8f));
  endproperty
  a_write_takes: assert property (p_write_takes)
    else $error("ctrl did not take masked write");

  property p_hold;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    !(i_wr && sel_hit) |=> $stable(state_reg.ctrl);
  endproperty
  a_hold: assert property (p_hold)
    else $error("ctrl changed without a write");

  property p_reserved_zero;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    state_reg.ctrl[6:4] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not zero");

  sequence s_rd_other;
    i_rd && !sel_hit;
  endsequence
  property p_unmapped;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    s_rd_other |=> (o_rdata == 8'h00) && !o_hit;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_readback;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_rd && sel_hit && !i_wr)
      |=> o_hit && (o_rdata == $past(state_reg.ctrl));
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback mismatch");

  property p_pin;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    o_pin_out == (state_reg.ctrl[7] ? i_secure_clk : i_port_three_bit_four);
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin mux wrong");

  property p_aux;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    !aux_on |-> !o_aux_one && !o_aux_two;
  endproperty
  a_aux: assert property (p_aux)
    else $error("aux driven while disabled");

  property p_select;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (state_reg.ctrl[2:0] == 3'h2)
      |-> (o_error_probe_signal == i_checksum_fault_flag);
  endproperty
  a_select: assert property (p_select)
    else $error("probe select wrong");

  // each select value checked on its own against pbus.flags, the vector the mux reads, so a wrong mux index shows by index
  for (genvar k = 0; k < scep_pkg::SCEP_NUM_ERR; k++)
  begin : g_src_chk
    property p_source;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      (state_reg.ctrl[scep_pkg::SCEP_SEL_MSB:0] == 3'(k))
        |-> (o_error_probe_signal == pbus.flags[k]);
    endproperty
    a_source: assert property (p_source)
      else $error("probe does not follow the selected flag");
  end

  // built from the pins, not from aux_on, so a wrong enable term shows
  property p_aux_on;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (state_reg.ctrl[3] && (i_aux_output_select_one == 4'ha)
      && (i_aux_output_select_two == 4'ha))
      |-> (o_aux_one == o_error_probe_signal)
        && (o_aux_two == o_error_probe_signal);
  endproperty
  a_aux_on: assert property (p_aux_on)
    else $error("aux pads do not carry the probe");

  property p_hit_only;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    !(i_rd && sel_hit) |=> !o_hit;
  endproperty
  a_hit_only: assert property (p_hit_only)
    else $error("hit without a read of the register");

  // read data is a register so the core may sample it late
  property p_rdata_hold;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    !i_rd |=> $stable(o_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");

  sequence s_wr_ctrl;
    i_wr && sel_hit;
  endsequence
  sequence s_rd_ctrl;
    i_rd && sel_hit;
  endsequence
  // a read that meets a write returns the value from before the write
  property p_rd_during_wr;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    s_wr_ctrl ##0 s_rd_ctrl |=> (o_rdata == $past(state_reg.ctrl));
  endproperty
  a_rd_during_wr: assert property (p_rd_during_wr)
    else $error("read with write did not return old value");
endmodule : scep_regs

// File: verif/scep_core_model.sv
// bus master standing in for the core
// assumes the bench calls cyc once a clock
`timescale 1ns/10ps
module scep_core_model
(
  input  wire logic        i_clk_sys,
  output logic      [15:0] o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [7:0]  o_wdata
);
  initial
  begin
    o_addr  = 16'h0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end
  // every strobe set each call, so none moves twice in a step
  task automatic cyc(input logic w, input logic r, input logic [15:0] a,
                     input logic [7:0] d);
    @(negedge i_clk_sys);
    o_addr  = a;
    o_wr    = w;
    o_rd    = r;
    o_wdata = w ? d : ~o_wdata;
  endtask : cyc
endmodule : scep_core_model

// File: verif/scep_regs_tb_top.sv
// bench for the clock pin and error probe register
// assumes scep_regs and the core model
`timescale 1ns/10ps
module scep_regs_tb_top;
  logic        i_clk_sys = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_secure_clk = 1'b0;
  logic        i_port_three_bit_four = 1'b0;
  logic [3:0]  i_aux_output_select_one = 4'h0;
  logic [3:0]  i_aux_output_select_two = 4'h0;
  logic [15:0] addr;
  logic        wr, rd, o_hit, o_pin_out, o_aux_one, o_aux_two;
  logic        o_error_probe_signal;
  logic [3:0]  outs;
  assign outs = {o_pin_out, o_aux_one, o_aux_two, o_error_probe_signal};
  logic [7:0]  fl = 8'h00, d, ctrl, wdata, o_rdata;
  int          error_cnt = 0, n_tests = 0, cyc_cnt = 0, seed = 32'hefc9;
  scep_regs dut (.i_clk_sys, .i_nrst, .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_wdata(wdata), .o_rdata, .o_hit, .i_secure_clk, .i_port_three_bit_four,
    .o_pin_out, .i_aux_output_select_one, .i_aux_output_select_two,
    .i_protocol_violation_flag(fl[0]), .i_parity_fault_flag(fl[1]),
    .i_checksum_fault_flag(fl[2]), .i_collision_fault_flag(fl[3]),
    .i_fifo_overflow_flag(fl[4]), .i_field_fault_flag(fl[5]),
    .i_overheat_fault_flag(fl[6]), .i_write_fault_flag(fl[7]), .o_aux_one,
    .o_aux_two, .o_error_probe_signal);
  scep_core_model core (.i_clk_sys, .o_addr(addr), .o_wr(wr), .o_rd(rd),
    .o_wdata(wdata));
  always #50 i_clk_sys = ~i_clk_sys;
  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      error_cnt++;
  endtask : chk
  // read strobe, then one idle cycle before looking at the answer
  task automatic rdck(input logic [15:0] a, input logic [7:0] e);
    core.cyc(1'b0, 1'b1, a, 8'h00);
    core.cyc(1'b0, 1'b0, a, 8'h00);
    chk(o_rdata, e);
    chk({7'h00, o_hit}, {7'h00, a == 16'h6330});
  endtask : rdck
  // pin, aux pads and probe from control value and live inputs
  function automatic logic [7:0] pins(input logic [7:0] c);
    logic p;
    p = fl[c[2:0]];
    p = p & c[3] & (i_aux_output_select_one == 4'ha);
    return {4'h0, c[7] ? i_secure_clk : i_port_three_bit_four,
      p & (i_aux_output_select_two == 4'ha),
      p & (i_aux_output_select_two == 4'ha), fl[c[2:0]]};
  endfunction : pins
  always @(posedge i_clk_sys)
  begin
    cyc_cnt++;
    if (cyc_cnt == 2000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_nrst = 1'b1;
    rdck(16'h6330, 8'h00);
    for (int i = 0; i < 48; i++)
    begin
      d = 8'($random(seed));
      d[2:0] = i[2:0];
      ctrl = d & 8'h8f;
      core.cyc(1'b1, 1'b0, 16'h6330, d);
      core.cyc(1'b1, 1'b0, 16'h6330 ^ (16'h1 << i[3:0]), ~d);
      rdck(16'h6330, ctrl);
      rdck(16'h6331 + 16'(i), 8'h00);
      {i_secure_clk, i_port_three_bit_four} = 2'($random(seed));
      fl = 8'($random(seed));
      i_aux_output_select_one = i[4] ? 4'ha : 4'($random(seed));
      i_aux_output_select_two = i[5] ? 4'($random(seed)) : 4'ha;
      core.cyc(1'b0, 1'b0, 16'h6330, 8'h00);
      chk(outs, pins(ctrl));
    end
    // write and read in one cycle: the read returns the old value
    core.cyc(1'b1, 1'b1, 16'h6330, 8'h80);
    core.cyc(1'b0, 1'b0, 16'h6330, 8'h00);
    chk(o_rdata, ctrl);
    rdck(16'h6330, 8'h80);
    chk(outs, pins(8'h80));
    i_nrst = 1'b0;
    core.cyc(1'b0, 1'b0, 16'h6330, 8'h00);
    i_nrst = 1'b1;
    rdck(16'h6330, 8'h00);
    chk(outs, pins(8'h00));
    complete_run();
  end
endmodule : scep_regs_tb_top
